/* logic/acr_config_regs.sv */
// Functional notes
// - Bits 7:5 of byte 1 pick the output rate from 20 to 1000 SPS, doubled in turbo, with code 111 reserved.
// - Bit 4 of byte 1 runs the modulator at 256 kHz when zero and 512 kHz when one.
// - Bit 3 of byte 1 selects single-shot conversion when zero and continuous conversion when one.
// - Bits 2:1 of byte 1 select internal reference, external reference inputs, or the analog supply for 10 and 11.
// - Bit 0 of byte 1 enters temperature mode, which ignores byte 0 and forces the internal reference.
// - Bit 7 of byte 2 is a read-only new-result flag that resets to zero.
// - The new-result flag clears when the host reads the conversion data with no new result arriving in the same cycle.
// - Bit 6 of byte 2 enables the conversion data counter, off by default.
// - Bits 5:4 of byte 2 choose no check, appended inverted data, or appended CRC16, with 11 reserved.
// - Bit 3 of byte 2 switches the 10 uA burn-out sources on or off.
// - Bits 2:0 of byte 2 set one current level shared by both excitation sources.
// - Byte 1 sits at address 01h and resets to 00h.
// - Byte 2 sits at address 02h and resets to 00h.
// - Byte 3 sits at address 03h, resets to 00h, holds two routing fields and reads zero in bits 1:0.
// - Each routing field disables its source, routes it to an analog input, or to either reference input.
`timescale 1ns/1ps
module acr_config_regs
   import acr_pkg::*;
#(
   parameter logic [10:0] CODE6_UA = 11'd1000
) (
   // Clock and reset
   input  wire logic        MCLK_IN,
   input  wire logic        RESETN_IN,
   // Register port from the serial engine
   input  wire logic [7:0]  REG_ADDR_IN,
   input  wire logic        REG_WR_IN,
   input  wire logic [7:0]  REG_WDATA_IN,
   input  wire logic        REG_RD_IN,
   output logic [7:0]       REG_RDATA_OUT,
   // Converter events
   input  wire logic        RESULT_NEW_IN,
   input  wire logic        DATA_READ_IN,
   // Raw configuration fields
   output logic [2:0]       DATA_RATE_SEL_OUT,
   output logic             TURBO_MODE_OUT,
   output logic             CONVERSION_STYLE_OUT,
   output logic [1:0]       REFERENCE_CODE_OUT,
   output logic             TEMPERATURE_SENSE_ENABLE_OUT,
   output logic             RESULT_READY_FLAG_OUT,
   output logic             CONVERSION_COUNTER_ENABLE_OUT,
   output logic [1:0]       INTEGRITY_MODE_OUT,
   output logic             BURNOUT_SOURCE_ENABLE_OUT,
   output logic [2:0]       EXCITATION_CURRENT_LEVEL_OUT,
   output logic [2:0]       SOURCE_ONE_ROUTING_OUT,
   output logic [2:0]       SOURCE_TWO_ROUTING_OUT,
   // Decoded settings for the analog and data path
   output logic [11:0]      SAMPLE_RATE_SPS_OUT,
   output logic             RATE_VALID_OUT,
   output logic [9:0]       MOD_CLOCK_KHZ_OUT,
   output logic [1:0]       REFERENCE_SEL_OUT,
   output logic             CONFIG0_IGNORE_OUT,
   output logic             APPEND_INVERTED_OUT,
   output logic             APPEND_CRC_OUT,
   output logic [10:0]      EXCITATION_CURRENT_UA_OUT,
   output logic [5:0]       SOURCE_ONE_TARGET_OUT,
   output logic [5:0]       SOURCE_TWO_TARGET_OUT
);

   logic [7:0] rate_cfg_r;
   logic [6:0] ready_cfg_r;
   logic [5:0] routing_cfg_r;
   logic       ready_flag_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       wr_rate;
   logic       wr_ready;
   logic       wr_routing;
   logic [7:0] last_wdata_r;

   // Write strobes per byte
   assign wr_rate    = REG_WR_IN && (REG_ADDR_IN == ACR_ADDR_RATE_CFG);
   assign wr_ready   = REG_WR_IN && (REG_ADDR_IN == ACR_ADDR_READY_CFG);
   assign wr_routing = REG_WR_IN && (REG_ADDR_IN == ACR_ADDR_ROUTING_CFG);

   // Rate, mode and reference byte, fully writable
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         rate_cfg_r <= ACR_RATE_CFG_RST;
      end else if (wr_rate) begin
         rate_cfg_r <= REG_WDATA_IN;
      end
   end

   // Integrity and current byte; bit 7 is not stored here so writes cannot touch it
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         ready_cfg_r <= ACR_READY_CFG_RST[6:0];
      end else if (wr_ready) begin
         ready_cfg_r <= REG_WDATA_IN[6:0];
      end
   end

   // Routing byte; low two bits have no storage and read as zero
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         routing_cfg_r <= ACR_ROUTING_CFG_RST[7:2];
      end else if (wr_routing) begin
         routing_cfg_r <= REG_WDATA_IN[7:2];
      end
   end

   // New-result flag; a result landing with a data read wins so it is never lost
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         ready_flag_r <= 1'b0;
      end else if (RESULT_NEW_IN) begin
         ready_flag_r <= 1'b1;
      end else if (DATA_READ_IN) begin
         ready_flag_r <= 1'b0;
      end
   end

   // Read mux; unmapped addresses, including byte 0 which lives elsewhere, read zero
   always_comb begin
      if (REG_ADDR_IN == ACR_ADDR_RATE_CFG) begin
         rdata_nxt = rate_cfg_r;
      end else if (REG_ADDR_IN == ACR_ADDR_READY_CFG) begin
         rdata_nxt = {ready_flag_r, ready_cfg_r};
      end else if (REG_ADDR_IN == ACR_ADDR_ROUTING_CFG) begin
         rdata_nxt = {routing_cfg_r, 2'b00};
      end else begin
         rdata_nxt = ACR_UNMAPPED_READ;
      end
   end

   // Read data is captured on the strobe and held until the next read
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         rdata_r <= 8'h00;
      end else if (REG_RD_IN) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign REG_RDATA_OUT = rdata_r;

   // Field outputs straight from the stored bytes
   assign DATA_RATE_SEL_OUT             = rate_cfg_r[ACR_DR_LSB +: 3];
   assign TURBO_MODE_OUT                = rate_cfg_r[ACR_MODE_BIT];
   assign CONVERSION_STYLE_OUT          = rate_cfg_r[ACR_CM_BIT];
   assign REFERENCE_CODE_OUT            = rate_cfg_r[ACR_VREF_LSB +: 2];
   assign TEMPERATURE_SENSE_ENABLE_OUT  = rate_cfg_r[ACR_TS_BIT];
   assign RESULT_READY_FLAG_OUT         = ready_flag_r;
   assign CONVERSION_COUNTER_ENABLE_OUT = ready_cfg_r[ACR_CNT_BIT];
   assign INTEGRITY_MODE_OUT            = ready_cfg_r[ACR_INT_LSB +: 2];
   assign BURNOUT_SOURCE_ENABLE_OUT     = ready_cfg_r[ACR_BCS_BIT];
   assign EXCITATION_CURRENT_LEVEL_OUT  = ready_cfg_r[ACR_IDAC_LSB +: 3];
   assign SOURCE_ONE_ROUTING_OUT        = routing_cfg_r[ACR_R1_LSB-2 +: 3];
   assign SOURCE_TWO_ROUTING_OUT        = routing_cfg_r[ACR_R2_LSB-2 +: 3];

   // Decoded settings lag the stored fields by one clock
   acr_field_decode #(
      .CODE6_UA          (CODE6_UA)
   ) u_decode (
      .clk_in            (MCLK_IN),
      .resetn_in         (RESETN_IN),
      .rate_code_in      (DATA_RATE_SEL_OUT),
      .turbo_in          (TURBO_MODE_OUT),
      .ref_code_in       (REFERENCE_CODE_OUT),
      .temp_mode_in      (TEMPERATURE_SENSE_ENABLE_OUT),
      .integrity_in      (INTEGRITY_MODE_OUT),
      .current_code_in   (EXCITATION_CURRENT_LEVEL_OUT),
      .route_one_in      (SOURCE_ONE_ROUTING_OUT),
      .route_two_in      (SOURCE_TWO_ROUTING_OUT),
      .sps_out           (SAMPLE_RATE_SPS_OUT),
      .rate_valid_out    (RATE_VALID_OUT),
      .mod_khz_out       (MOD_CLOCK_KHZ_OUT),
      .ref_eff_out       (REFERENCE_SEL_OUT),
      .cfg0_ignore_out   (CONFIG0_IGNORE_OUT),
      .append_inv_out    (APPEND_INVERTED_OUT),
      .append_crc_out    (APPEND_CRC_OUT),
      .current_ua_out    (EXCITATION_CURRENT_UA_OUT),
      .route_one_hot_out (SOURCE_ONE_TARGET_OUT),
      .route_two_hot_out (SOURCE_TWO_TARGET_OUT)
   );

   // Helper for checks: last write data seen
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         last_wdata_r <= 8'h00;
      end else begin
         last_wdata_r <= REG_WDATA_IN;
      end
   end

   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (!RESETN_IN);

   sequence seq_turbo_top_write;
      wr_rate && (REG_WDATA_IN[7:4] == 4'h d);
   endsequence

   sequence seq_rate_quiet;
      !wr_rate;
   endsequence

   sequence seq_current_top_write;
      wr_ready && (REG_WDATA_IN[2:0] == 3'h7);
   endsequence

   sequence seq_ready_quiet;
      !wr_ready;
   endsequence

   // Write to byte 1 lands in its rate, conversion style and reference fields
   chk_rate_write: assert property (wr_rate |=> (DATA_RATE_SEL_OUT == last_wdata_r[7:5])
      && (CONVERSION_STYLE_OUT == last_wdata_r[3]) && (REFERENCE_CODE_OUT == last_wdata_r[2:1]))
      else $error("byte 1 write not stored");

   // Top turbo code gives 2000 once the field and then the decoder have moved
   chk_turbo_rate: assert property (seq_turbo_top_write ##1 seq_rate_quiet |=>
      ##1 ((SAMPLE_RATE_SPS_OUT == 12'd2000) && RATE_VALID_OUT))
      else $error("turbo top rate not 2000");

   // Modulator clock follows the speed bit
   chk_speed_clock: assert property (TURBO_MODE_OUT && $stable(TURBO_MODE_OUT)
      |-> MOD_CLOCK_KHZ_OUT == ACR_MOD_KHZ_TURBO)
      else $error("turbo clock mismatch");

   // Temperature mode forces internal reference and ignores byte 0
   chk_temp_reference: assert property (TEMPERATURE_SENSE_ENABLE_OUT |=>
      (REFERENCE_SEL_OUT == ACR_REF_INTERNAL) && CONFIG0_IGNORE_OUT)
      else $error("temperature mode reference wrong");

   // New result raises the flag
   chk_ready_set: assert property (RESULT_NEW_IN |=> RESULT_READY_FLAG_OUT)
      else $error("ready flag not set");

   // Data read clears the flag unless a new result arrives at once
   chk_ready_clear: assert property (DATA_READ_IN && !RESULT_NEW_IN
      |=> !RESULT_READY_FLAG_OUT)
      else $error("ready flag not cleared");

   // Host writes never move the flag
   chk_ready_hold: assert property (wr_ready && !RESULT_NEW_IN && !DATA_READ_IN
      |=> RESULT_READY_FLAG_OUT == $past(RESULT_READY_FLAG_OUT))
      else $error("write disturbed ready flag");

   // Byte 2 counter, integrity and burn-out fields take write data
   chk_byte2_write: assert property (wr_ready |=> (CONVERSION_COUNTER_ENABLE_OUT == last_wdata_r[6])
      && (BURNOUT_SOURCE_ENABLE_OUT == last_wdata_r[3]) && (INTEGRITY_MODE_OUT == last_wdata_r[5:4]))
      else $error("byte 2 write not stored");

   // CRC code appends only the checksum
   chk_integrity_crc: assert property (INTEGRITY_MODE_OUT == ACR_INT_CRC |=>
      APPEND_CRC_OUT && !APPEND_INVERTED_OUT)
      else $error("crc mode decode wrong");

   // Top current code gives 1500 uA
   chk_current_top: assert property (seq_current_top_write ##1 seq_ready_quiet |=>
      ##1 (EXCITATION_CURRENT_UA_OUT == 11'd1500))
      else $error("current top level wrong");

   // Routing byte reads zero in its low bits
   chk_reg3_low_zero: assert property (REG_RD_IN && (REG_ADDR_IN == ACR_ADDR_ROUTING_CFG)
      |=> REG_RDATA_OUT[1:0] == 2'b00)
      else $error("reserved bits read nonzero");

   // Positive reference routing drives that target only
   chk_route_ext_reference_positive: assert property (SOURCE_ONE_ROUTING_OUT == 3'h5 |=>
      SOURCE_ONE_TARGET_OUT == ACR_ROUTE_EXT_REFERENCE_POSITIVE_HOT)
      else $error("source one routing wrong");

   // Reset leaves byte 1 at its reset value
   chk_reset_byte1: assert property (!$past(RESETN_IN) |-> rate_cfg_r == ACR_RATE_CFG_RST)
      else $error("byte 1 reset value wrong");

   // Reset leaves bytes 2 and 3 at their reset values, flag included
   chk_reset_byte23: assert property (!$past(RESETN_IN)
      |-> ({ready_flag_r, ready_cfg_r} == ACR_READY_CFG_RST) && ({routing_cfg_r, 2'b00} == ACR_ROUTING_CFG_RST))
      else $error("byte 2 or 3 reset value wrong");

   // Reserved rate code gives no valid rate
   chk_rate_reserved: assert property (DATA_RATE_SEL_OUT == 3'h7 |=>
      !RATE_VALID_OUT && (SAMPLE_RATE_SPS_OUT == 12'h000))
      else $error("reserved rate code decoded");

   // Normal speed keeps the slow modulator clock
   chk_normal_clock: assert property (!TURBO_MODE_OUT |=>
      MOD_CLOCK_KHZ_OUT == ACR_MOD_KHZ_NORMAL)
      else $error("normal clock mismatch");

   // Outside temperature mode the chosen reference passes through
   chk_ref_pass: assert property (!TEMPERATURE_SENSE_ENABLE_OUT |=>
      REFERENCE_SEL_OUT == $past(REFERENCE_CODE_OUT))
      else $error("reference selection wrong");

   // Inverted-data code appends only the inverted copy
   chk_integrity_inv: assert property (INTEGRITY_MODE_OUT == ACR_INT_INVERTED |=>
      APPEND_INVERTED_OUT && !APPEND_CRC_OUT)
      else $error("inverted mode decode wrong");

   // Routing write lands in both fields; the low bits have no storage to disturb
   chk_routing_write: assert property (wr_routing |=>
      {SOURCE_ONE_ROUTING_OUT, SOURCE_TWO_ROUTING_OUT} == last_wdata_r[7:2])
      else $error("byte 3 write not stored");

endmodule

/* logic/acr_field_decode.sv */
`timescale 1ns/1ps
module acr_field_decode
   import acr_pkg::*;
#(
   parameter logic [10:0] CODE6_UA = 11'd1000
) (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   // Raw fields
   input  wire logic [2:0]  rate_code_in,
   input  wire logic        turbo_in,
   input  wire logic [1:0]  ref_code_in,
   input  wire logic        temp_mode_in,
   input  wire logic [1:0]  integrity_in,
   input  wire logic [2:0]  current_code_in,
   input  wire logic [2:0]  route_one_in,
   input  wire logic [2:0]  route_two_in,
   // Decoded, registered
   output logic [11:0]      sps_out,
   output logic             rate_valid_out,
   output logic [9:0]       mod_khz_out,
   output logic [1:0]       ref_eff_out,
   output logic             cfg0_ignore_out,
   output logic             append_inv_out,
   output logic             append_crc_out,
   output logic [10:0]      current_ua_out,
   output logic [5:0]       route_one_hot_out,
   output logic [5:0]       route_two_hot_out
);

   logic [11:0] base_sps;

   // Turbo doubles the normal rate; top code 2000 still fits 12 bits
   assign base_sps = acr_rate_sps(rate_code_in);

   // Rate and modulator speed
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         sps_out        <= ACR_SPS_0;
         rate_valid_out <= 1'b1;
         mod_khz_out    <= ACR_MOD_KHZ_NORMAL;
      end else begin
         sps_out        <= turbo_in ? {base_sps[10:0], 1'b0} : base_sps;
         rate_valid_out <= (rate_code_in != 3'h7);
         mod_khz_out    <= turbo_in ? ACR_MOD_KHZ_TURBO : ACR_MOD_KHZ_NORMAL;
      end
   end

   // Reference, forced internal while the temperature sensor measures
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         ref_eff_out     <= ACR_REF_INTERNAL;
         cfg0_ignore_out <= 1'b0;
      end else begin
         ref_eff_out     <= temp_mode_in ? ACR_REF_INTERNAL : ref_code_in;
         cfg0_ignore_out <= temp_mode_in;
      end
   end

   // Integrity scheme; reserved code appends nothing
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         append_inv_out <= 1'b0;
         append_crc_out <= 1'b0;
      end else begin
         append_inv_out <= (integrity_in == ACR_INT_INVERTED);
         append_crc_out <= (integrity_in == ACR_INT_CRC);
      end
   end

   // Excitation level and routing
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         current_ua_out    <= 11'h000;
         route_one_hot_out <= 6'h00;
         route_two_hot_out <= 6'h00;
      end else begin
         current_ua_out    <= acr_current_ua(current_code_in, CODE6_UA);
         route_one_hot_out <= acr_route_onehot(route_one_in);
         route_two_hot_out <= acr_route_onehot(route_two_in);
      end
   end

endmodule

/* logic/acr_pkg.sv */
package acr_pkg;

   // Register addresses
   localparam logic [7:0] ACR_ADDR_RATE_CFG    = 8'h01;
   localparam logic [7:0] ACR_ADDR_READY_CFG   = 8'h02;
   localparam logic [7:0] ACR_ADDR_ROUTING_CFG = 8'h03;

   // Reset values
   localparam logic [7:0] ACR_RATE_CFG_RST    = 8'h00;
   localparam logic [7:0] ACR_READY_CFG_RST   = 8'h00;
   localparam logic [7:0] ACR_ROUTING_CFG_RST = 8'h00;
   localparam logic [7:0] ACR_UNMAPPED_READ   = 8'h00;

   // Field positions, rate / mode / reference byte
   localparam int ACR_DR_LSB   = 5;
   localparam int ACR_MODE_BIT = 4;
   localparam int ACR_CM_BIT   = 3;
   localparam int ACR_VREF_LSB = 1;
   localparam int ACR_TS_BIT   = 0;

   // Field positions, ready / integrity / current byte
   localparam int ACR_RDY_BIT  = 7;
   localparam int ACR_CNT_BIT  = 6;
   localparam int ACR_INT_LSB  = 4;
   localparam int ACR_BCS_BIT  = 3;
   localparam int ACR_IDAC_LSB = 0;

   // Field positions, routing byte
   localparam int ACR_R1_LSB = 5;
   localparam int ACR_R2_LSB = 2;

   // Reference source codes
   localparam logic [1:0] ACR_REF_INTERNAL = 2'b00;
   localparam logic [1:0] ACR_REF_EXTERNAL = 2'b01;

   // Integrity scheme codes
   localparam logic [1:0] ACR_INT_NONE     = 2'b00;
   localparam logic [1:0] ACR_INT_INVERTED = 2'b01;
   localparam logic [1:0] ACR_INT_CRC      = 2'b10;

   // Modulator clock in kHz
   localparam logic [9:0] ACR_MOD_KHZ_NORMAL = 10'h100;
   localparam logic [9:0] ACR_MOD_KHZ_TURBO  = 10'h200;

   // Normal speed output rates in samples per second
   localparam logic [11:0] ACR_SPS_0 = 12'd20;
   localparam logic [11:0] ACR_SPS_1 = 12'd45;
   localparam logic [11:0] ACR_SPS_2 = 12'd90;
   localparam logic [11:0] ACR_SPS_3 = 12'd175;
   localparam logic [11:0] ACR_SPS_4 = 12'd330;
   localparam logic [11:0] ACR_SPS_5 = 12'd600;
   localparam logic [11:0] ACR_SPS_6 = 12'd1000;

   // Excitation current in microamps
   localparam logic [10:0] ACR_UA_1 = 11'd10;
   localparam logic [10:0] ACR_UA_2 = 11'd50;
   localparam logic [10:0] ACR_UA_3 = 11'd100;
   localparam logic [10:0] ACR_UA_4 = 11'd250;
   localparam logic [10:0] ACR_UA_5 = 11'd500;
   localparam logic [10:0] ACR_UA_7 = 11'd1500;

   // One-hot route targets: bit 0..3 analog inputs, 4 positive ref, 5 negative ref
   localparam logic [5:0] ACR_ROUTE_EXT_REFERENCE_POSITIVE_HOT = 6'h10;

   // Normal speed rate; reserved code yields zero
   function automatic logic [11:0] acr_rate_sps(input logic [2:0] code);
      case (code)
         3'h0:    acr_rate_sps = ACR_SPS_0;
         3'h1:    acr_rate_sps = ACR_SPS_1;
         3'h2:    acr_rate_sps = ACR_SPS_2;
         3'h3:    acr_rate_sps = ACR_SPS_3;
         3'h4:    acr_rate_sps = ACR_SPS_4;
         3'h5:    acr_rate_sps = ACR_SPS_5;
         3'h6:    acr_rate_sps = ACR_SPS_6;
         default: acr_rate_sps = 12'h000;
      endcase
   endfunction

   // Shared current level for both sources
   function automatic logic [10:0] acr_current_ua(input logic [2:0] code, input logic [10:0] code6_ua);
      case (code)
         3'h1:    acr_current_ua = ACR_UA_1;
         3'h2:    acr_current_ua = ACR_UA_2;
         3'h3:    acr_current_ua = ACR_UA_3;
         3'h4:    acr_current_ua = ACR_UA_4;
         3'h5:    acr_current_ua = ACR_UA_5;
         3'h6:    acr_current_ua = code6_ua;
         3'h7:    acr_current_ua = ACR_UA_7;
         default: acr_current_ua = 11'h000;
      endcase
   endfunction

   // Routing field to one-hot target; off and reserved drive nothing
   function automatic logic [5:0] acr_route_onehot(input logic [2:0] code);
      case (code)
         3'h1:    acr_route_onehot = 6'h01;
         3'h2:    acr_route_onehot = 6'h02;
         3'h3:    acr_route_onehot = 6'h04;
         3'h4:    acr_route_onehot = 6'h08;
         3'h5:    acr_route_onehot = ACR_ROUTE_EXT_REFERENCE_POSITIVE_HOT;
         3'h6:    acr_route_onehot = 6'h20;
         default: acr_route_onehot = 6'h00;
      endcase
   endfunction

endpackage

/* testbench/acr_host_model.sv */
`timescale 1ns/1ps
// Register-port host: one-cycle strobes, launched just after an edge
module acr_host_model (
   // Clock and control
   input  wire logic       clk_in,
   input  wire logic       bad_in,
   // Register port
   output logic [7:0]      addr_out,
   output logic            wr_out,
   output logic [7:0]      wdata_out,
   output logic            rd_out
);
   // Idle values before the first request
   initial begin
      addr_out  = 8'h00;
      wr_out    = 1'b0;
      wdata_out = 8'h00;
      rd_out    = 1'b0;
   end

   // Write; bad_in lets the bench set the low reserved bits on purpose
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      #2;
      addr_out  = a;
      wdata_out = (a == 8'h03 && !bad_in) ? {d[7:2], 2'b00} : d;
      wr_out    = 1'b1;
      @(posedge clk_in);
      #2;
      wr_out    = 1'b0;
      wdata_out = ~wdata_out;  // Released data never shows the last value
      addr_out  = ~addr_out;
   endtask

   // Read strobe; the answer is picked up by the bench monitor
   task automatic rd(input logic [7:0] a);
      @(posedge clk_in);
      #2;
      addr_out = a;
      rd_out   = 1'b1;
      @(posedge clk_in);
      #2;
      rd_out   = 1'b0;
      addr_out = ~addr_out;
   endtask
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
   import acr_pkg::*;
   localparam logic [10:0] C6 = 11'd1000;
   logic clk, rstn, new_r, dr_r, bad_r, rd_seen;
   logic [7:0] rdata, d, b2;
   logic [2:0] sel, cur, r1, r2;
   logic [1:0] vref, integ;
   logic turbo, cm, ts, cnt, burnout_source_enable, rv;
   logic [11:0] sps;
   logic [9:0] khz;
   logic [1:0] refsel;
   logic ign, ainv, acrc, flag;
   logic [10:0] ua;
   logic [5:0] t1, t2;
   logic [7:0] q[$];
   int mismatches = 0, checked = 0, seed = 78574;
   int rate[8] = '{20, 45, 90, 175, 330, 600, 1000, 0};
   int amp[8] = '{0, 10, 50, 100, 250, 500, 1000, 1500};
   int hot[8] = '{0, 1, 2, 4, 8, 16, 32, 0};
   wire logic [7:0] addr, wdata;
   wire logic wr, rd;

   acr_host_model u_host (.clk_in(clk), .bad_in(bad_r), .addr_out(addr), .wr_out(wr),
      .wdata_out(wdata), .rd_out(rd));

   acr_config_regs #(.CODE6_UA(C6)) u_dut (.MCLK_IN(clk), .RESETN_IN(rstn), .REG_ADDR_IN(addr),
      .REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
      .RESULT_NEW_IN(new_r), .DATA_READ_IN(dr_r), .DATA_RATE_SEL_OUT(sel), .TURBO_MODE_OUT(turbo),
      .CONVERSION_STYLE_OUT(cm), .REFERENCE_CODE_OUT(vref), .TEMPERATURE_SENSE_ENABLE_OUT(ts),
      .RESULT_READY_FLAG_OUT(flag), .CONVERSION_COUNTER_ENABLE_OUT(cnt), .INTEGRITY_MODE_OUT(integ),
      .BURNOUT_SOURCE_ENABLE_OUT(burnout_source_enable), .EXCITATION_CURRENT_LEVEL_OUT(cur), .SOURCE_ONE_ROUTING_OUT(r1),
      .SOURCE_TWO_ROUTING_OUT(r2), .SAMPLE_RATE_SPS_OUT(sps), .RATE_VALID_OUT(rv),
      .MOD_CLOCK_KHZ_OUT(khz), .REFERENCE_SEL_OUT(refsel), .CONFIG0_IGNORE_OUT(ign),
      .APPEND_INVERTED_OUT(ainv), .APPEND_CRC_OUT(acrc), .EXCITATION_CURRENT_UA_OUT(ua),
      .SOURCE_ONE_TARGET_OUT(t1), .SOURCE_TWO_TARGET_OUT(t2));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Read monitor: answer lands one edge after the strobe, checked a cycle later
   always @(posedge clk) begin
      #1;
      if (rd_seen) begin
         `CHK(rdata, q.pop_front())
      end
      rd_seen = rd;
   end

   // Verdict and end of run
   task automatic end_sim;
      if (mismatches == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Read with the expected byte noted first
   task automatic rdx(input logic [7:0] a, input logic [7:0] e);
      q.push_back(e);
      u_host.rd(a);
   endtask

   // Write then wait for the decoded outputs, one more edge
   task automatic wrx(input logic [7:0] a, input logic [7:0] e);
      u_host.wr(a, e);
      @(posedge clk);
      #2;
   endtask

   // Converter event pulse of one cycle
   task automatic pulse(input logic n, input logic r);
      @(posedge clk);
      #2;
      new_r = n;
      dr_r  = r;
      @(posedge clk);
      #2;
      new_r = 1'b0;
      dr_r  = 1'b0;
   endtask

   // Watchdog: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      end_sim();
   end

   // Main sequence
   initial begin
      rstn = 1'b0; new_r = 1'b0; dr_r = 1'b0; bad_r = 1'b0; rd_seen = 1'b0;
      repeat (4) @(posedge clk);
      #2;
      rstn = 1'b1;
      for (int p = 0; p < 2; p++) begin
         // Reset values, unmapped addresses read zero
         for (int a = 0; a < 5; a++) rdx(8'(a), 8'h00);
         `CHK(flag, 1'b0)
         `CHK(sps, 12'(20))
         // Every rate code in both speeds, other byte 1 fields random
         for (int i = 0; i < 16; i++) begin
            d = {i[2:0], i[3], 4'($random(seed))};
            wrx(8'h01, d);
            `CHK(sps, 12'(rate[i[2:0]] << i[3]))
            `CHK(rv, 1'(i[2:0] != 7))
            `CHK(khz, (i[3] ? 10'(512) : 10'(256)))
            `CHK({sel, turbo, cm, vref, ts}, d)
            `CHK(refsel, (d[0] ? 2'b00 : d[2:1]))
            `CHK(ign, d[0])
         end
         rdx(8'h01, d);
         // Byte 2 with every current code, flag bit written as one
         for (int i = 0; i < 8; i++) begin
            d = {1'b1, 4'($random(seed)), i[2:0]};
            b2 = d;
            wrx(8'h02, d);
            `CHK({cnt, integ, burnout_source_enable, cur}, d[6:0])
            `CHK(flag, 1'b0)
            `CHK({ainv, acrc}, {1'(d[5:4] == 2'b01), 1'(d[5:4] == 2'b10)})
            `CHK(ua, 11'(amp[i]))
            rdx(8'h02, {1'b0, d[6:0]});
         end
         // Routing codes, low reserved bits sometimes forced to ones
         for (int i = 0; i < 8; i++) begin
            bad_r = i[0];
            d = {i[2:0], 3'(7 - i), 2'b11};
            wrx(8'h03, d);
            `CHK({r1, r2}, d[7:2])
            `CHK({t1, t2}, {6'(hot[i]), 6'(hot[7 - i])})
            rdx(8'h03, {d[7:2], 2'b00});
         end
         bad_r = 1'b0;
         // Unmapped writes leave the routing byte alone
         u_host.wr(8'h04, 8'hff);
         u_host.wr(8'h00, 8'hff);
         rdx(8'h03, {d[7:2], 2'b00});
         rdx(8'h04, 8'h00);
         // Flag: set, kept over a register read, cleared by data read, set wins
         pulse(1'b1, 1'b0);
         `CHK(flag, 1'b1)
         wrx(8'h02, {1'b0, b2[6:0]});
         `CHK(flag, 1'b1)
         rdx(8'h02, {1'b1, b2[6:0]});
         `CHK(flag, 1'b1)
         pulse(1'b0, 1'b1);
         `CHK(flag, 1'b0)
         pulse(1'b1, 1'b1);
         `CHK(flag, 1'b1)
         // Second reset in mid run
         @(posedge clk);
         #2;
         rstn = 1'b0;
         repeat (2) @(posedge clk);
         #2;
         rstn = 1'b1;
      end
      repeat (3) @(posedge clk);
      `CHK(q.size(), 0)
      end_sim();
   end
endmodule
